// File: nand_ecc_defines.svh
// Purpose: named offsets, field positions and reset values of the
//          sector result register block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   included by its bare name; definitions only
`ifndef NAND_ECC_DEFINES_SVH
`define NAND_ECC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ECC_OFS_CTRL      8'h00
`define ECC_OFS_STATUS    8'h04
`define ECC_OFS_IRQ_EN    8'h08
`define ECC_OFS_IRQ_CLR   8'h0C
`define ECC_OFS_S5_512    8'h20
`define ECC_OFS_S6_512    8'h24
`define ECC_OFS_S7_512    8'h28
`define ECC_OFS_S0_256    8'h30
`define ECC_OFS_S1_256    8'h34
`define ECC_OFS_S2_256    8'h38

// ----------------------------------------------------------------
// result field positions
// ----------------------------------------------------------------
`define ECC_BIT_LSB       0
`define ECC_BIT_MSB       2
`define ECC_W512_MSB      11
`define ECC_W256_MSB      10
`define ECC_P_LSB         12
`define ECC_P512_MSB      23
`define ECC_P256_MSB      22
`define ECC_CHK512_MSB    11
`define ECC_CHK256_MSB    10

// ----------------------------------------------------------------
// page geometry
// ----------------------------------------------------------------
`define ECC_FIRST_S512    3'h5
`define ECC_SHIFT_512     9
`define ECC_SHIFT_256     8

// ----------------------------------------------------------------
// status and control bits and reset values
// ----------------------------------------------------------------
`define ECC_ST_DONE       0
`define ECC_ST_ERR        1
`define ECC_CTRL_LAYOUT   0
`define ECC_RST_WORD      32'h0000_0000
`define ECC_RST_EVT       2'h0

`endif

// File: nand_ecc_pkg.sv
// Purpose: shared types of the sector result register block
// Assumes: nothing beyond the defines header
// Notes:   widths follow the largest sector layout
package nand_ecc_pkg;
   typedef enum logic {LAYOUT_512, LAYOUT_256} layout_t;
   typedef enum logic {PG_IDLE, PG_RUN} page_state_t;
   typedef logic [11:0] chk_t;
   typedef logic [1:0]  evt_t;
endpackage

// File: ecc_sector_calc.sv
// Purpose: running check-bit accumulator for one sector
// Assumes: one byte per enabled cycle, index valid with it
// Notes:   check bits are the xor of {word, bit} over every set bit
`timescale 1ns/10ps
`default_nettype none
`include "nand_ecc_defines.svh"

module ecc_sector_calc
   import nand_ecc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        clear,
   input  wire logic        en,
   input  wire logic [8:0]  wordIdx,
   input  wire logic [7:0]  dataByte,
   output nand_ecc_pkg::chk_t checkBits
);
   import nand_ecc_pkg::*;

   chk_t       acc_r;
   chk_t       acc_nxt;
   logic [2:0] bitXor;
   logic       oddOnes;

   // ----------------------------------------------------------------
   // per-byte contribution
   // ----------------------------------------------------------------
   // an odd number of ones contributes the word index once, even cancels
   always_comb begin
      bitXor  = 3'h0;
      oddOnes = ^dataByte;
      for (int k = 0; k < 8; k++) begin
         if (dataByte[k]) begin
            bitXor = bitXor ^ k[2:0];
         end
      end
      acc_nxt = acc_r;
      if (clear) begin
         acc_nxt = 12'h000;
      end else if (en) begin
         acc_nxt = acc_r ^ {(oddOnes ? wordIdx : 9'h000), bitXor};
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc_r <= 12'h000;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   assign checkBits = acc_r;
endmodule
`default_nettype wire

// File: ecc_irq_ctrl.sv
// Purpose: sticky event status, enable mask and level interrupt
// Assumes: events and clears are one-cycle pulses on core_clk
// Notes:   a set in the clear cycle wins over the clear
`timescale 1ns/10ps
`default_nettype none
`include "nand_ecc_defines.svh"

module ecc_irq_ctrl
   import nand_ecc_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          rst,
   input  wire nand_ecc_pkg::evt_t evtSet,
   input  wire nand_ecc_pkg::evt_t clrMask,
   input  wire logic          enWrite,
   input  wire nand_ecc_pkg::evt_t enData,
   output nand_ecc_pkg::evt_t status,
   output nand_ecc_pkg::evt_t enable,
   output logic               irq
);
   import nand_ecc_pkg::*;

   evt_t status_r;
   evt_t status_nxt;
   evt_t enable_r;
   evt_t enable_nxt;
   logic irq_r;
   logic irq_nxt;

   // ----------------------------------------------------------------
   // status, mask and output level
   // ----------------------------------------------------------------
   always_comb begin
      status_nxt = (status_r & ~clrMask) | evtSet;
      enable_nxt = enWrite ? enData : enable_r;
      irq_nxt    = |(status_nxt & enable_nxt);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         status_r <= `ECC_RST_EVT;
         enable_r <= `ECC_RST_EVT;
         irq_r    <= 1'b0;
      end else begin
         status_r <= status_nxt;
         enable_r <= enable_nxt;
         irq_r    <= irq_nxt;
      end
   end

   assign status = status_r;
   assign enable = enable_r;
   assign irq    = irq_r;
endmodule
`default_nettype wire

// File: nand_sector_ecc_result_regs.sv
// Purpose: per-sector ecc result registers behind an APB slave
// Assumes: page bytes arrive in order on core_clk, one per valid cycle
// Notes:   three sectors tracked; which three depends on the layout
`timescale 1ns/10ps
`default_nettype none
`include "nand_ecc_defines.svh"

// Notes on behaviour
// - 512 layout: sectors 5-7 cover bytes 2560-4095
// - 256 layout: sectors 0-2 cover bytes 0-767
// - 512 fields: bit 2:0, word 11:3, parity 23:12
// - 256 fields: bit 2:0, word 10:3, parity 22:12
// - single error loads the flipped bit offset
// - single error loads the bad byte index
// - positions meaningless after multiple errors
module nand_sector_ecc_result_regs
   import nand_ecc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pageStart,
   input  wire logic        pageIsRead,
   input  wire logic        pageEnd,
   input  wire logic        dataValid,
   input  wire logic [7:0]  dataByte,
   input  wire logic        refValid,
   input  wire logic [1:0]  refSector,
   input  wire nand_ecc_pkg::chk_t refBits,
   output logic             irq
);
   import nand_ecc_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   page_state_t state_r;
   page_state_t state_nxt;
   layout_t     layout_r;
   layout_t     layout_nxt;
   logic [11:0] byteCnt_r;
   logic [11:0] byteCnt_nxt;
   logic        isRead_r;
   logic        isRead_nxt;
   chk_t        syn_r [3];
   chk_t        syn_nxt [3];
   chk_t        chk [3];
   logic [2:0]  hit;
   logic [8:0]  wordIdx;
   logic        calcClear;
   logic        beat;
   evt_t        evtSet;
   evt_t        clrMask;
   evt_t        status;
   evt_t        enable;
   logic        enWrite;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic        pready_r;
   logic        pready_nxt;
   logic        pslverr_r;
   logic        pslverr_nxt;
   logic [31:0] rdWord;
   logic        rdHit;
   logic        wrDone;
   logic        sectorErr;

   // ----------------------------------------------------------------
   // page sequencing
   // ----------------------------------------------------------------
   // a new page restarts the byte count and clears every accumulator
   always_comb begin
      state_nxt   = state_r;
      byteCnt_nxt = byteCnt_r;
      isRead_nxt  = isRead_r;
      calcClear   = 1'b0;
      unique case (state_r)
         PG_IDLE: begin
            if (pageStart) begin
               state_nxt   = PG_RUN;
               byteCnt_nxt = 12'h000;
               isRead_nxt  = pageIsRead;
               calcClear   = 1'b1;
            end
         end
         PG_RUN: begin
            if (pageEnd) begin
               state_nxt = PG_IDLE;
            end else if (dataValid) begin
               byteCnt_nxt = byteCnt_r + 12'h001;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r   <= PG_IDLE;
         byteCnt_r <= 12'h000;
         isRead_r  <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         byteCnt_r <= byteCnt_nxt;
         isRead_r  <= isRead_nxt;
      end
   end

   assign beat = (state_r == PG_RUN) && dataValid && !pageEnd;

   // ----------------------------------------------------------------
   // sector selection and check-bit accumulation
   // ----------------------------------------------------------------
   // word index is the byte offset inside the sector; the 256 layout
   // keeps its top bit zero so check bit 11 stays zero there
   always_comb begin
      if (layout_r == LAYOUT_512) begin
         wordIdx = byteCnt_r[8:0];
      end else begin
         wordIdx = {1'b0, byteCnt_r[7:0]};
      end
   end

   generate
      for (genvar s = 0; s < 3; s++) begin : g_sec
         always_comb begin
            if (layout_r == LAYOUT_512) begin
               hit[s] = (byteCnt_r[11:`ECC_SHIFT_512] ==
                         3'(`ECC_FIRST_S512 + s));
            end else begin
               hit[s] = (byteCnt_r[11:`ECC_SHIFT_256] ==
                         4'(s));
            end
         end

         ecc_sector_calc u_calc (
            .core_clk  (core_clk),
            .rst       (rst),
            .clear     (calcClear),
            .en        (beat && hit[s]),
            .wordIdx   (wordIdx),
            .dataByte  (dataByte),
            .checkBits (chk[s])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // error location on read
   // ----------------------------------------------------------------
   // syndrome of stored against computed bits is the flipped position;
   // a write page or a fresh page leaves the positions at zero
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         syn_nxt[i] = syn_r[i];
         if (calcClear) begin
            syn_nxt[i] = 12'h000;
         end else if (refValid && isRead_r && refSector == 2'(i)) begin
            syn_nxt[i] = refBits ^ chk[i];
         end
      end
      sectorErr = refValid && isRead_r && (refSector != 2'h3) &&
                  ((refBits ^ chk[refSector]) != 12'h000);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            syn_r[i] <= 12'h000;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            syn_r[i] <= syn_nxt[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // events and interrupt
   // ----------------------------------------------------------------
   assign evtSet = {sectorErr, (state_r == PG_RUN) && pageEnd};
   assign wrDone = psel && penable && pready_r && pwrite;
   assign clrMask = (wrDone && paddr == `ECC_OFS_IRQ_CLR) ?
                    pwdata[1:0] : 2'h0;
   assign enWrite = wrDone && (paddr == `ECC_OFS_IRQ_EN);

   ecc_irq_ctrl u_irq (
      .core_clk (core_clk),
      .rst      (rst),
      .evtSet   (evtSet),
      .clrMask  (clrMask),
      .enWrite  (enWrite),
      .enData   (pwdata[1:0]),
      .status   (status),
      .enable   (enable),
      .irq      (irq)
   );

   // ----------------------------------------------------------------
   // layout control
   // ----------------------------------------------------------------
   // changing layout mid-page mixes sectors; software sets it while idle
   always_comb begin
      layout_nxt = layout_r;
      if (wrDone && paddr == `ECC_OFS_CTRL) begin
         layout_nxt = pwdata[`ECC_CTRL_LAYOUT] ? LAYOUT_256 : LAYOUT_512;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         layout_r <= LAYOUT_512;
      end else begin
         layout_r <= layout_nxt;
      end
   end

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   // a result register of the other layout reads as zero
   always_comb begin
      rdWord = `ECC_RST_WORD;
      rdHit  = 1'b1;
      unique case (paddr)
         `ECC_OFS_CTRL:    rdWord[`ECC_CTRL_LAYOUT] = (layout_r == LAYOUT_256);
         `ECC_OFS_STATUS:  rdWord[1:0] = status;
         `ECC_OFS_IRQ_EN:  rdWord[1:0] = enable;
         `ECC_OFS_IRQ_CLR: rdWord = `ECC_RST_WORD;
         `ECC_OFS_S5_512, `ECC_OFS_S6_512, `ECC_OFS_S7_512: begin
            if (layout_r == LAYOUT_512) begin
               rdWord[`ECC_W512_MSB:`ECC_BIT_LSB] =
                  syn_r[paddr[3:2]][`ECC_CHK512_MSB:0];
               rdWord[`ECC_P512_MSB:`ECC_P_LSB] =
                  chk[paddr[3:2]][`ECC_CHK512_MSB:0];
            end
         end
         `ECC_OFS_S0_256, `ECC_OFS_S1_256, `ECC_OFS_S2_256: begin
            if (layout_r == LAYOUT_256) begin
               // bits 11 and 23 stay zero
               rdWord[`ECC_W256_MSB:`ECC_BIT_LSB] =
                  syn_r[paddr[3:2]][`ECC_CHK256_MSB:0];
               rdWord[`ECC_P256_MSB:`ECC_P_LSB] =
                  chk[paddr[3:2]][`ECC_CHK256_MSB:0];
            end
         end
         default: rdHit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // APB handshake
   // ----------------------------------------------------------------
   // one wait state so prdata, pready and pslverr come from flops;
   // writes to result registers are accepted and change nothing
   always_comb begin
      pready_nxt  = psel && penable && !pready_r;
      prdata_nxt  = prdata_r;
      pslverr_nxt = 1'b0;
      if (pready_nxt) begin
         prdata_nxt  = pwrite ? `ECC_RST_WORD : rdWord;
         pslverr_nxt = !rdHit;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata_r  <= `ECC_RST_WORD;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
endmodule
`default_nettype wire

// File: ecc_result_chk.sv
// Purpose: port assertions for the sector result register block
// Assumes: one apb wait state, irq moves in the same cycle as status
// Notes:   bound from the bench top file
`timescale 1ns/10ps
`default_nettype none
`include "nand_ecc_defines.svh"
module ecc_result_chk (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic        pageEnd,
   input  wire logic        refValid,
   input  wire logic        irq
);
   import nand_ecc_pkg::*;
   evt_t enMir_r;
   evt_t enMir_nxt;
   logic done;
   logic is512;
   logic is256;
   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   // access decode; enable is mirrored since it is not a port
   assign done  = psel && penable && pready;
   assign is512 = paddr inside {`ECC_OFS_S5_512, `ECC_OFS_S6_512,
                                `ECC_OFS_S7_512};
   assign is256 = paddr inside {`ECC_OFS_S0_256, `ECC_OFS_S1_256,
                                `ECC_OFS_S2_256};
   always_comb begin
      enMir_nxt = enMir_r;
      if (done && pwrite && paddr == `ECC_OFS_IRQ_EN)
         enMir_nxt = pwdata[1:0];
   end
   always_ff @(posedge core_clk) begin
      if (rst)
         enMir_r <= `ECC_RST_EVT;
      else
         enMir_r <= enMir_nxt;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("access did not end after one wait");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_reset_idle: assert property ($fell(rst) |->
      !pready && !irq && prdata == 32'h0000_0000)
      else $error("outputs not idle after reset");
   chk_hi512_zero: assert property (
      done && !pwrite && is512 |-> prdata[31:24] == 8'h00)
      else $error("upper bits set in 512 result");
   chk_hi256_zero: assert property (
      done && !pwrite && is256 |-> prdata[31:23] == 9'h000 && !prdata[11])
      else $error("zero bits set in 256 result");
   chk_res_noerr: assert property (
      done && (is512 || is256) |-> !pslverr)
      else $error("result access flagged as error");
   chk_done_irq: assert property (pageEnd && enMir_r[0] |-> ##1 irq)
      else $error("page end raised no interrupt");
   chk_irq_masked: assert property (irq |-> enMir_r != 2'h0)
      else $error("interrupt while masked");
   chk_clr_drop: assert property (done && pwrite && !pageEnd && !refValid
      && paddr == `ECC_OFS_IRQ_CLR && pwdata[1:0] == 2'h3 |-> ##1 !irq)
      else $error("interrupt stayed after clear");
endmodule
`default_nettype wire

// File: nand_page_model.sv
// Purpose: behavioural page data path feeding the result block
// Assumes: bytes go out in page order, one per cycle
// Notes:   the bench fills the set-bit tables before each page
`timescale 1ns/10ps
`default_nettype none
module nand_page_model (
   input  wire logic          core_clk,
   output logic               pageStart,
   output logic               pageIsRead,
   output logic               pageEnd,
   output logic               dataValid,
   output logic [7:0]         dataByte,
   output logic               refValid,
   output logic [1:0]         refSector,
   output nand_ecc_pkg::chk_t refBits
);
   import nand_ecc_pkg::*;
   int hotIdx [8];
   int hotBit [8];
   // idle levels at time zero
   initial begin
      pageStart  = 1'b0;
      pageIsRead = 1'b0;
      pageEnd    = 1'b0;
      dataValid  = 1'b0;
      dataByte   = 8'h00;
      refValid   = 1'b0;
      refSector  = 2'h0;
      refBits    = 12'h000;
   end
   // byte k of the page: zero except the listed set bits
   function automatic logic [7:0] byteAt(input int k);
      logic [7:0] v;
      v = 8'h00;
      for (int i = 0; i < 8; i++)
         if (hotIdx[i] == k) v[hotBit[i]] = ~v[hotBit[i]];
      return v;
   endfunction
   task automatic runPage(input logic rd, input int n);
      @(posedge core_clk);
      pageStart  <= 1'b1;
      pageIsRead <= rd;
      @(posedge core_clk);
      pageStart <= 1'b0;
      for (int k = 0; k < n; k++) begin
         dataValid <= 1'b1;
         dataByte  <= byteAt(k);
         @(posedge core_clk);
      end
      dataValid <= 1'b0;
      dataByte  <= ~dataByte; // released bus must not look stable
   endtask
   task automatic sendRef(input logic [1:0] s, input chk_t b);
      @(posedge core_clk);
      refValid  <= 1'b1;
      refSector <= s;
      refBits   <= b;
      @(posedge core_clk);
      refValid <= 1'b0;
      refBits  <= ~b;
   endtask
   task automatic endPage();
      @(posedge core_clk);
      pageEnd <= 1'b1;
      @(posedge core_clk);
      pageEnd <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb_nand_sector_ecc_result_regs.sv
// Purpose: self-checking bench for the sector result register block
// Assumes: page model drives the data path, apb tasks the registers
// Notes:   each layout runs a clean write page then a faulty read page
`timescale 1ns/10ps
`default_nettype none
`include "nand_ecc_defines.svh"
module tb_nand_sector_ecc_result_regs;
   import nand_ecc_pkg::*;
   logic        core_clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pageStart;
   logic        pageIsRead;
   logic        pageEnd;
   logic        dataValid;
   logic [7:0]  dataByte;
   logic        refValid;
   logic [1:0]  refSector;
   chk_t        refBits;
   logic        irq;
   logic [31:0] rdq;
   logic        rde;
   int          errTotal;
   int          cmpCount;
   // --------------------------------------------------------------
   // clock, design and page model
   // --------------------------------------------------------------
   initial core_clk = 1'b0;
   always #25 core_clk = ~core_clk;
   nand_sector_ecc_result_regs u_dut (.core_clk(core_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pageStart(pageStart), .pageIsRead(pageIsRead),
      .pageEnd(pageEnd), .dataValid(dataValid), .dataByte(dataByte),
      .refValid(refValid), .refSector(refSector), .refBits(refBits),
      .irq(irq));
   nand_page_model u_page (.core_clk(core_clk), .pageStart(pageStart),
      .pageIsRead(pageIsRead), .pageEnd(pageEnd), .dataValid(dataValid),
      .dataByte(dataByte), .refValid(refValid), .refSector(refSector),
      .refBits(refBits));
   task automatic wrapUp();
      $display("mismatches %0d compares %0d", errTotal, cmpCount);
      if (errTotal == 0 && cmpCount > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         errTotal++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chkBit(input logic got, input logic exp);
      chkWord({31'h0000_0000, got}, {31'h0000_0000, exp});
   endtask
   // one apb transfer; waits for ready, only the watchdog bounds it
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rdq = prdata;
      rde = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chkWord(rdq, exp);
   endtask
   // check bits of one sector: xor of {word, bit} of every set bit
   function automatic chk_t calc(input int lo, input int sz);
      chk_t c;
      c = 12'h000;
      for (int i = 0; i < 8; i++)
         if (u_page.hotIdx[i] >= lo && u_page.hotIdx[i] < lo + sz)
            c ^= 12'((u_page.hotIdx[i] - lo) * 8 + u_page.hotBit[i]);
      return c;
   endfunction
   task automatic runLayout(input logic l256, input int base,
                            input int sz, input int n, input logic [7:0] ofs);
      chk_t        par [3];
      chk_t        syn;
      logic [31:0] exp;
      apb(1'b1, `ECC_OFS_CTRL, {31'h0000_0000, l256});
      rdChk(`ECC_OFS_CTRL, {31'h0000_0000, l256});
      apb(1'b1, `ECC_OFS_IRQ_EN, 32'h0000_0003);
      // set bits on first or last byte of each sector
      for (int i = 0; i < 8; i++) begin
         u_page.hotIdx[i] = (i < 3) ?
                            base + i * sz + (i == 1 ? 0 : sz - 1) : -1;
         u_page.hotBit[i] = (i < 3) ? 3 * i + 1 : 0;
      end
      u_page.runPage(1'b0, n);
      u_page.sendRef(2'h0, 12'hfff); // refused on a write page
      u_page.endPage();
      rdChk(`ECC_OFS_STATUS, 32'h0000_0001);
      chkBit(irq, 1'b1);
      for (int s = 0; s < 3; s++) begin
         // positions stay zero after a write page
         exp = {8'h00, calc(base + s * sz, sz), 12'h000};
         rdChk(ofs + 8'(4 * s), exp);
         par[s] = rdq[23:12];
      end
      apb(1'b1, `ECC_OFS_IRQ_CLR, 32'h0000_0003);
      rdChk(`ECC_OFS_STATUS, 32'h0000_0000);
      chkBit(irq, 1'b0);
      // read page: one flip per sector plus a stray bit outside them
      u_page.hotIdx[3] = (base == 0) ? 3 * sz : base - 1;
      u_page.hotBit[3] = 2;
      for (int s = 0; s < 3; s++) begin
         u_page.hotIdx[4 + s] = base + s * sz + sz / 2 + 37 * s;
         u_page.hotBit[4 + s] = 6 - 2 * s;
      end
      u_page.runPage(1'b1, n);
      for (int s = 0; s < 3; s++)
         u_page.sendRef(2'(s), par[s]);
      u_page.endPage();
      for (int s = 0; s < 3; s++) begin
         syn = 12'((sz / 2 + 37 * s) * 8 + 6 - 2 * s);
         exp = {8'h00, calc(base + s * sz, sz), syn};
         rdChk(ofs + 8'(4 * s), exp);
      end
      rdChk(`ECC_OFS_STATUS, 32'h0000_0003);
      chkBit(irq, 1'b1);
      apb(1'b1, ofs + 8'h08, 32'hFFFF_FFFF);
      chkBit(rde, 1'b0);
      rdChk(ofs + 8'h08, exp);
      apb(1'b1, `ECC_OFS_IRQ_EN, 32'h0000_0000);
      rdChk(`ECC_OFS_STATUS, 32'h0000_0003);
      chkBit(irq, 1'b0);
      apb(1'b1, `ECC_OFS_IRQ_CLR, 32'h0000_0003);
   endtask
   // --------------------------------------------------------------
   // main sequence and watchdog
   // --------------------------------------------------------------
   initial begin
      errTotal = 0;
      cmpCount = 0;
      rst      = 1'b1;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 8'h00;
      pwdata   = 32'h0000_0000;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      rdChk(`ECC_OFS_CTRL, `ECC_RST_WORD);
      rdChk(`ECC_OFS_S5_512, `ECC_RST_WORD);
      rdChk(`ECC_OFS_S0_256, `ECC_RST_WORD);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chkBit(rde, 1'b1);
      runLayout(1'b0, 2560, 512, 4096, `ECC_OFS_S5_512);
      runLayout(1'b1, 0, 256, 1024, `ECC_OFS_S0_256);
      wrapUp();
   end
   // the run needs some 11000 cycles
   initial begin
      repeat (40000) @(posedge core_clk);
      errTotal++;
      $display("[ERR] %0t watchdog expired", $time);
      wrapUp();
   end
endmodule
bind nand_sector_ecc_result_regs ecc_result_chk u_chk (
   .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pageEnd(pageEnd),
   .refValid(refValid), .irq(irq));
`default_nettype wire
